// File: rtl/sors_pkg.sv
// Package: constants for the software option and ramp selector
package sors_pkg;
	localparam int          RAMP_W        = 16;
	localparam int          ENTRIES       = 8;
	localparam logic [2:0]  SEL_RESET     = 3'h0;
	localparam logic [2:0]  GRPA_NONE     = 3'h1;
	localparam logic [2:0]  GRPA_PRESET_SPEED_REQUEST     = 3'h2;
	localparam logic [2:0]  GRPA_PATTERN  = 3'h3;
	localparam logic [2:0]  GRPA_TRAVERSE = 3'h4;
	localparam logic [1:0]  GRPB_NONE     = 2'h1;
	localparam logic [1:0]  GRPB_FEEDBACK = 2'h2;
	localparam logic [1:0]  GRPB_PUMP     = 2'h3;
	localparam logic [1:0]  MODE_BINARY   = 2'h1;
	localparam logic [1:0]  MODE_DIRECT   = 2'h2;
endpackage

// File: rtl/sors_selector.sv
// Module: option decode, program ramp selection and feedback loop gating
`timescale 1ns/1ps
`default_nettype none
module sors_selector #(
	parameter int RAMP_W = sors_pkg::RAMP_W
)(
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic [2:0]            function_group_a_choice,
	input  wire logic [1:0]            function_group_b_choice,
	input  wire logic [1:0]            selection_mode_setting,
	input  wire logic [8*RAMP_W-1:0]   accel_ramp_table,
	input  wire logic [8*RAMP_W-1:0]   decel_ramp_table,
	input  wire logic [RAMP_W-1:0]     accel_ramp_time_2,
	input  wire logic [RAMP_W-1:0]     decel_ramp_time_2,
	input  wire logic                  preset_speed_request,
	input  wire logic                  pick_bit0,
	input  wire logic                  pick_bit1,
	input  wire logic                  pick_bit2,
	input  wire logic                  pick_bit3,
	input  wire logic                  upper_bank_choice,
	input  wire logic                  alt_ramp_choice,
	input  wire logic                  feedback_loop_on,
	input  wire logic                  forward_run_cmd,
	input  wire logic                  reverse_run_cmd,
	input  wire logic                  local_mode,
	output logic                       preset_speed_request_ramp_active,
	output logic                       pattern_run_active,
	output logic                       traverse_run_active,
	output logic                       feedback_func_active,
	output logic                       multipump_active,
	output logic                       preset_speed_active,
	output logic [2:0]                 ramp_entry,
	output logic                       alt_ramp_used,
	output logic [RAMP_W-1:0]          accel_time,
	output logic [RAMP_W-1:0]          decel_time,
	output logic                       feedback_loop_run
);
	// Two-stage synchronisers for the pin inputs; stage one is read only by stage two
	localparam int NSYNC = 11;
	logic [NSYNC-1:0] pins;
	logic [NSYNC-1:0] s1_q;
	logic [NSYNC-1:0] s2_q;
	assign pins = {local_mode, reverse_run_cmd, forward_run_cmd, feedback_loop_on, alt_ramp_choice,
		upper_bank_choice, pick_bit3, pick_bit2, pick_bit1, pick_bit0, preset_speed_request};

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_q <= '0;
			s2_q <= '0;
		end
		else
		begin
			s1_q <= pins;
			s2_q <= s1_q;
		end
	end

	wire        req_s   = s2_q[0];
	wire [3:0]  pick_s  = s2_q[4:1];
	wire        bank_s  = s2_q[5];
	wire        alt_s   = s2_q[6];
	wire        fbon_s  = s2_q[7];
	wire        fwd_s   = s2_q[8];
	wire        rev_s   = s2_q[9];
	wire        local_s = s2_q[10];

	// Option decode
	wire preset_speed_request_w    = (function_group_a_choice == sors_pkg::GRPA_PRESET_SPEED_REQUEST);
	wire pattern_w = (function_group_a_choice == sors_pkg::GRPA_PATTERN);
	wire travers_w = (function_group_a_choice == sors_pkg::GRPA_TRAVERSE);
	wire fbfunc_w  = (function_group_b_choice == sors_pkg::GRPB_FEEDBACK);
	wire pump_w    = (function_group_b_choice == sors_pkg::GRPB_PUMP);

	// Entry selection; a multi-hot direct pattern is not documented, lowest bit wins
	logic       dir_hit;
	logic [1:0] dir_idx;
	always_comb
	begin
		dir_hit = 1'b1;
		dir_idx = 2'h0;
		if (pick_s[0])
			dir_idx = 2'h0;
		else if (pick_s[1])
			dir_idx = 2'h1;
		else if (pick_s[2])
			dir_idx = 2'h2;
		else if (pick_s[3])
			dir_idx = 2'h3;
		else
			dir_hit = 1'b0;
	end

	logic [2:0] sel_q;
	logic [2:0] sel_d;
	wire  [2:0] bin_idx = pick_s[2:0];
	wire  [2:0] dir_full = {bank_s, dir_idx};
	// Selection ignores the preset speed request, so the request never freezes the ramp entry
	assign sel_d = (selection_mode_setting == sors_pkg::MODE_BINARY) ? bin_idx :
		((selection_mode_setting == sors_pkg::MODE_DIRECT) && dir_hit) ? dir_full : sel_q;

	// Table unpacking, one entry per generate step
	logic [RAMP_W-1:0] acc_e [sors_pkg::ENTRIES];
	logic [RAMP_W-1:0] dec_e [sors_pkg::ENTRIES];
	genvar gi;
	generate
		for (gi = 0; gi < sors_pkg::ENTRIES; gi++)
		begin : g_ent
			assign acc_e[gi] = accel_ramp_table[gi*RAMP_W +: RAMP_W];
			assign dec_e[gi] = decel_ramp_table[gi*RAMP_W +: RAMP_W];
		end
	endgenerate

	// Alternate pair wins over the table even in program ramp mode
	wire               use_alt   = alt_s;
	wire [RAMP_W-1:0]  acc_d     = use_alt ? accel_ramp_time_2 : acc_e[sel_d];
	wire [RAMP_W-1:0]  dec_d     = use_alt ? decel_ramp_time_2 : dec_e[sel_d];
	wire               fb_run_d  = fbfunc_w && fbon_s && (fwd_s || rev_s) && !local_s;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sel_q                <= sors_pkg::SEL_RESET;
			accel_time           <= '0;
			decel_time           <= '0;
			alt_ramp_used        <= 1'b0;
			preset_speed_request_ramp_active     <= 1'b0;
			pattern_run_active   <= 1'b0;
			traverse_run_active  <= 1'b0;
			feedback_func_active <= 1'b0;
			multipump_active     <= 1'b0;
			preset_speed_active  <= 1'b0;
			feedback_loop_run    <= 1'b0;
		end
		else
		begin
			sel_q                <= sel_d;
			accel_time           <= acc_d;
			decel_time           <= dec_d;
			alt_ramp_used        <= use_alt;
			preset_speed_request_ramp_active     <= preset_speed_request_w;
			pattern_run_active   <= pattern_w;
			traverse_run_active  <= travers_w;
			feedback_func_active <= fbfunc_w;
			multipump_active     <= pump_w;
			preset_speed_active  <= preset_speed_request_w && req_s;
			feedback_loop_run    <= fb_run_d;
		end
	end

	assign ramp_entry = sel_q;
endmodule
`default_nettype wire

// File: verif/sors_sva.sv
// Checker on the selector's ports
`timescale 1ns/1ps
`default_nettype none
module sors_sva #(parameter int RAMP_W = 16) (
	input wire logic clk, nrst, pick_bit0, pick_bit1, pick_bit2, pick_bit3, upper_bank_choice, local_mode,
	input wire logic alt_ramp_used, feedback_loop_on, feedback_loop_run, preset_speed_request_ramp_active, multipump_active,
	input wire logic [2:0] function_group_a_choice, ramp_entry,
	input wire logic [1:0] function_group_b_choice, selection_mode_setting,
	input wire logic [RAMP_W-1:0] accel_ramp_time_2, accel_time
);
	wire [1:0] md = selection_mode_setting;
	wire [3:0] pk = {pick_bit3, pick_bit2, pick_bit1, pick_bit0};
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_grpa; 1 |=> preset_speed_request_ramp_active == ($past(function_group_a_choice) == 3'h2); endproperty
	a_grpa: assert property (p_grpa) else $error("group A decode");
	property p_grpb; 1 |=> multipump_active == ($past(function_group_b_choice) == 2'h3); endproperty
	a_grpb: assert property (p_grpb) else $error("group B decode");
	property p_alt; alt_ramp_used |-> accel_time == $past(accel_ramp_time_2); endproperty
	a_alt: assert property (p_alt) else $error("second ramp");
	// Pins reach the selection three edges late through the synchroniser
	property p_bin; md == 2'h1 [*4] |=> ramp_entry == $past(pk[2:0], 3); endproperty
	a_bin: assert property (p_bin) else $error("binary pick");
	property p_dir; md == 2'h2 [*4] ##0 $onehot($past(pk, 2)) |=>
		ramp_entry == {$past(upper_bank_choice, 3), $past(pk[3] | pk[2], 3), $past(pk[3] | pk[1], 3)}; endproperty
	a_dir: assert property (p_dir) else $error("direct pick");
	property p_hold; (md == 2'h2 && pk == 4'h0) [*4] |=> $stable(ramp_entry); endproperty
	a_hold: assert property (p_hold) else $error("hold lost");
	property p_fben; feedback_loop_run |-> $past(feedback_loop_on, 3) && !$past(local_mode, 3); endproperty
	a_fben: assert property (p_fben) else $error("loop gate");
	property p_fbgb; feedback_loop_run |-> $past(function_group_b_choice) == 2'h2; endproperty
	a_fbgb: assert property (p_fbgb) else $error("loop group");
endmodule
bind sors_selector sors_sva #(.RAMP_W(RAMP_W)) sors_sva_i (.*);
`default_nettype wire

// File: verif/sors_seq_ctrl.sv
// Sequence controller model driving the digital inputs
`timescale 1ns/1ps
`default_nettype none
module sors_seq_ctrl (
	input  wire logic        clk,
	input  wire logic [10:0] cmd,
	output logic      [10:0] pins
);
	logic [10:0] q = 11'h000;
	// Contacts move after the falling edge so the drive never samples one mid-change
	always @(negedge clk) q <= cmd;
	assign pins = q;
endmodule
`default_nettype wire

// File: verif/sors_selector_tb_top.sv
// Bench for the option and ramp selector
`timescale 1ns/1ps
`default_nettype none
module sors_selector_tb_top;
	logic clk = 1'b0, nrst = 1'b0;
	logic [2:0] function_group_a_choice = 3'h1;
	logic [1:0] function_group_b_choice = 2'h1, selection_mode_setting = 2'h2;
	logic [127:0] accel_ramp_table, decel_ramp_table;
	logic [15:0] accel_ramp_time_2 = 16'h2222, decel_ramp_time_2 = 16'h3333;
	logic [10:0] cmd = 11'h000;
	wire [10:0] pins;
	wire [2:0] ramp_entry;
	wire [15:0] accel_time, decel_time;
	wire preset_speed_request, pick_bit0, pick_bit1, pick_bit2, pick_bit3, upper_bank_choice, alt_ramp_choice;
	wire feedback_loop_on, forward_run_cmd, reverse_run_cmd, local_mode, preset_speed_request_ramp_active, pattern_run_active;
	wire traverse_run_active, feedback_func_active, multipump_active, preset_speed_active, alt_ramp_used;
	wire feedback_loop_run;
	int failures = 0, checked = 0;
	assign {local_mode, reverse_run_cmd, forward_run_cmd, feedback_loop_on, alt_ramp_choice, upper_bank_choice,
		pick_bit3, pick_bit2, pick_bit1, pick_bit0, preset_speed_request} = pins;
	always #10 clk = ~clk;
	sors_seq_ctrl sors_seq_ctrl_i (.clk(clk), .cmd(cmd), .pins(pins));
	sors_selector sors_selector_i (.*);
	task automatic cmp(input logic [34:0] g, e);
		checked++;
		if (g !== e) begin failures++; $display("unexpected at %0t: %h not %h", $time, g, e); end
	endtask
	// Five falling edges cover the model's half cycle plus the three-edge pin latency
	task automatic step(input logic [10:0] c);
		cmd <= c;
		repeat (5) @(negedge clk);
	endtask
	task automatic sel(input logic [10:0] c, input logic [2:0] e);
		step(c);
		cmp({ramp_entry, accel_time, decel_time}, {e, accel_ramp_table[e*16 +: 16], decel_ramp_table[e*16 +: 16]});
	endtask
	task automatic report_and_stop;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 8; i++) {accel_ramp_table[i*16 +: 16], decel_ramp_table[i*16 +: 16]} = {16'hA00 | 16'(i), 16'hD00 | 16'(i)};
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		sel(11'h020, 3'h0);
		$display("reset test done");
		for (int a = 1; a < 5; a++) begin
			function_group_a_choice = 3'(a);
			step(11'h000);
			cmp({preset_speed_request_ramp_active, pattern_run_active, traverse_run_active}, {a == 2, a == 3, a == 4});
		end
		function_group_a_choice = 3'h1;
		for (int b = 1; b < 4; b++) begin
			function_group_b_choice = 2'(b);
			step(11'h000);
			cmp({feedback_func_active, multipump_active}, {b == 2, b == 3});
		end
		$display("group test done");
		selection_mode_setting = 2'h1;
		for (int i = 0; i < 8; i++) sel(11'h030 | 11'(i << 1), 3'(i));
		selection_mode_setting = 2'h2;
		for (int i = 0; i < 8; i++) sel(11'(i[2] * 32 + (2 << i[1:0])), 3'(i));
		sel(11'h000, 3'h7);
		step(11'h040);
		cmp({ramp_entry, accel_time, decel_time}, {3'h7, 16'h2222, 16'h3333});
		cmp(alt_ramp_used, 1'b1);
		$display("ramp test done");
		function_group_b_choice = 2'h2;
		for (int i = 0; i < 3; i++) begin
			step(11'h080 | 11'(i << 8));
			cmp(feedback_loop_run, i != 0);
		end
		step(11'h580);
		cmp(feedback_loop_run, 1'b0);
		$display("loop test done");
		function_group_a_choice = 3'h2;
		step(11'h001);
		cmp(preset_speed_active, 1'b1);
		step(11'h000);
		cmp(preset_speed_active, 1'b0);
		$display("preset test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
